/* File: include/sleep_wake_pkg.sv */
// Purpose: shared constants for the sleep and wake controller
// Assumes: 8-bit register port, 100 MHz system clock
// Notes:   offsets are register indices on the plain register port
package sleep_wake_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_INTCTL  = 4'h0;
  localparam logic [3:0] OFS_PEN1    = 4'h1;
  localparam logic [3:0] OFS_PEN2    = 4'h2;
  localparam logic [3:0] OFS_PRQ1    = 4'h3;
  localparam logic [3:0] OFS_PRQ2    = 4'h4;
  localparam logic [3:0] OFS_STATUS  = 4'h5;
  localparam logic [3:0] OFS_WDCTL   = 4'h6;
  localparam logic [3:0] OFS_SLPSTAT = 4'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GLOBAL_IRQ_EN_BIT = 7;
  localparam int PERIPH_IRQ_EN_BIT = 6;
  localparam int TIME_OUT_BIT      = 4;
  localparam int POWER_DOWN_BIT    = 3;
  localparam int SOFT_WD_EN_BIT    = 0;
  localparam int PRQ2_LSB   = 3;   // bits 2..0 unimplemented

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] PRQ2_MASK    = 8'hF8;
  localparam logic [7:0] PRQ2_RST     = 8'h00;
  localparam logic [7:0] INTCTL_RST   = 8'h00;
  localparam logic [7:0] PEN_RST      = 8'h00;
  localparam logic [7:0] PRQ1_RST     = 8'h00;
  localparam logic [7:0] STATUS_RST   = 8'h18;  // both flags idle high
  localparam logic [7:0] WDCTL_RST    = 8'h16;
  localparam logic [7:0] WDCTL_MASK   = 8'h3F;
  localparam logic [7:0] INTCTL_FLAGS = 8'h07;  // core-level flags

  // ----------------------------------------------------------------
  // timing and vector
  // ----------------------------------------------------------------
  localparam int         STARTUP_PERIODS = 1024;    // oscillator periods
  localparam logic [15:0] ISR_VECTOR = 16'h0004;

  typedef enum logic [2:0] {
    ST_AWAKE   = 3'b000,
    ST_ENTER   = 3'b001,
    ST_ASLEEP  = 3'b010,
    ST_OSTWAIT = 3'b011,
    ST_RESUME  = 3'b100
  } sleep_state_t;

endpackage : sleep_wake_pkg

/* File: rtl/osc_startup_timer.sv */
// Purpose: counts oscillator periods after wake before execution resumes
// Assumes: osc_tick is a one-cycle pulse per oscillator period
// Notes:   done pulses once when the count completes
`timescale 1ns/10ps
module osc_startup_timer
  import sleep_wake_pkg::*;
#(
  parameter int PERIODS = STARTUP_PERIODS
)
(
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // control
  input  wire logic start,
  input  wire logic osc_tick,
  // status
  output logic      running,
  output logic      done
);

  localparam int CW = $clog2(PERIODS + 1);
  logic [CW-1:0] count_q;

  // counter reloads on start, stops at zero
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      count_q <= '0;
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
        count_q <= CW'(PERIODS);
      else if (count_q != '0 && osc_tick)
      begin
        count_q <= count_q - CW'(1);
        if (count_q == CW'(1))
          done <= 1'b1;
      end
    end
  end

  assign running = (count_q != '0);

endmodule : osc_startup_timer

/* File: rtl/sleep_wake_control.sv */
// Purpose: sleep entry, wake decision, status flags and interrupt flag regs
// Assumes: core issues a one-cycle sleep_exec pulse; sources pulse their set
// Notes:   reset-class wakes are external and clear everything by nrst
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
module sleep_wake_control
  import sleep_wake_pkg::*;
#(
  parameter int STARTUP_COUNT = STARTUP_PERIODS
)
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // cpu core
  input  wire logic        sleep_exec,
  input  wire logic [15:0] pc,
  output logic             cpu_clk_en,
  output logic             prefetch_en,
  output logic      [15:0] prefetch_addr,
  output logic             resume_pulse,
  output logic             isr_call,
  output logic      [15:0] isr_addr,
  // interrupt sources: set pulses
  input  wire logic [7:0]  prq1_set,
  input  wire logic [7:0]  prq2_set,
  input  wire logic [2:0]  core_flag_set,
  // watchdog and oscillator
  input  wire logic        wdt_timeout,
  input  wire logic        osc_tick,
  input  wire logic        slow_osc_mode,
  output logic             wdt_clear,
  output logic             wdt_run_in_sleep,
  output logic             wdt_timeout_reset,
  // keep-alive and pin hold
  output logic             lf_osc_en,
  output logic             sec_osc_en,
  output logic             conv_clk_en,
  output logic             sense_osc_en,
  output logic             pin_hold
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]   intctl_q, pen1_q, pen2_q, prq1_q, prq2_q, wdctl_q;
  logic         to_n_q, pd_n_q;
  logic [7:0]   rdata_q;
  logic         wake_wdt_q;
  sleep_state_t state_q;
  logic         wake_req, pend_any, su_start, su_run, su_done;
  logic         wr_intctl, wr_pen1, wr_pen2, wr_prq1, wr_prq2, wr_stat, wr_wd;

  assign wr_intctl = reg_write && reg_addr == OFS_INTCTL;
  assign wr_pen1   = reg_write && reg_addr == OFS_PEN1;
  assign wr_pen2   = reg_write && reg_addr == OFS_PEN2;
  assign wr_prq1   = reg_write && reg_addr == OFS_PRQ1;
  assign wr_prq2   = reg_write && reg_addr == OFS_PRQ2;
  assign wr_stat   = reg_write && reg_addr == OFS_STATUS;
  assign wr_wd     = reg_write && reg_addr == OFS_WDCTL;

  // ----------------------------------------------------------------
  // wake request
  // ----------------------------------------------------------------
  // OR of enabled flags
  always_comb
  begin
    pend_any = |(intctl_q[5:3] & intctl_q[2:0]);
    if (intctl_q[PERIPH_IRQ_EN_BIT])
      pend_any = pend_any | (|(pen1_q & prq1_q)) | (|(pen2_q & prq2_q & PRQ2_MASK));
  end

  assign wake_req = pend_any || wdt_timeout;

  // ----------------------------------------------------------------
  // interrupt enable and flag registers; hardware set beats clear
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      intctl_q <= INTCTL_RST;
    else if (wr_intctl)
      intctl_q <= reg_wdata | {5'h00, core_flag_set};
    else
      intctl_q <= intctl_q | {5'h00, core_flag_set};
  end

  // enables are plain software state
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pen1_q <= PEN_RST;
      pen2_q <= PEN_RST;
      wdctl_q <= WDCTL_RST;
    end
    else
    begin
      if (wr_pen1)
        pen1_q <= reg_wdata;
      if (wr_pen2)
        pen2_q <= reg_wdata & PRQ2_MASK;
      if (wr_wd)
        wdctl_q <= reg_wdata & WDCTL_MASK;
    end
  end

  // request flags: set pulse wins over a same-cycle write of zero
  // request two: five flags in bits 7..3; request one uses all eight bits
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      prq1_q <= PRQ1_RST;
      prq2_q <= PRQ2_RST;
    end
    else
    begin
      prq1_q <= (wr_prq1 ? reg_wdata : prq1_q) | prq1_set;
      prq2_q <= ((wr_prq2 ? reg_wdata : prq2_q) | prq2_set) & PRQ2_MASK;
    end
  end

  // ----------------------------------------------------------------
  // sleep sequencer
  // ----------------------------------------------------------------
  // only sleep_exec enters
  // pending flag makes sleep a no-op
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      state_q <= ST_AWAKE;
    else
    begin
      case (state_q)
        ST_AWAKE:
          if (sleep_exec && !pend_any)
            state_q <= ST_ENTER;
        ST_ENTER:
          state_q <= wake_req ? (slow_osc_mode ? ST_OSTWAIT : ST_RESUME) : ST_ASLEEP;
        ST_ASLEEP:
          if (wake_req)
            state_q <= slow_osc_mode ? ST_OSTWAIT : ST_RESUME;
        ST_OSTWAIT:
          if (su_done)
            state_q <= ST_RESUME;
        ST_RESUME:
          state_q <= ST_AWAKE;
        default:
          state_q <= ST_AWAKE;
      endcase
    end
  end

  // remember a watchdog wake for the status readback
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      wake_wdt_q <= 1'b0;
    else if (state_q == ST_ENTER)
      wake_wdt_q <= 1'b0;
    else if ((state_q == ST_ASLEEP) && wdt_timeout)
      wake_wdt_q <= 1'b1;
  end

  assign su_start = slow_osc_mode && wake_req
                    && (state_q == ST_ASLEEP || state_q == ST_ENTER);

  osc_startup_timer #(
    .PERIODS (STARTUP_COUNT)
  ) u_startup (
    .clock    (clock),
    .nrst     (nrst),
    .start    (su_start),
    .osc_tick (osc_tick),
    .running  (su_run),
    .done     (su_done)
  );

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // entry: power-down low, time-out high
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      to_n_q <= STATUS_RST[TIME_OUT_BIT];
      pd_n_q <= STATUS_RST[POWER_DOWN_BIT];
    end
    else if (sleep_exec && state_q == ST_AWAKE && !pend_any)
    begin
      to_n_q <= 1'b1;
      pd_n_q <= 1'b0;
    end
    else if (state_q == ST_ASLEEP && wdt_timeout)
      to_n_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // core-side outputs
  // ----------------------------------------------------------------
  // cpu clock gated while not awake
  assign cpu_clk_en = (state_q == ST_AWAKE);
  assign prefetch_en   = sleep_exec && state_q == ST_AWAKE;
  assign prefetch_addr = pc + 16'h0001;

  // resume inline; service call only with global enable
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      resume_pulse <= 1'b0;
      isr_call     <= 1'b0;
      isr_addr     <= 16'h0000;
    end
    else
    begin
      resume_pulse <= (state_q == ST_RESUME);
      isr_call     <= (state_q == ST_RESUME) && intctl_q[GLOBAL_IRQ_EN_BIT] && pend_any;
      isr_addr     <= ISR_VECTOR;
    end
  end

  assign wdt_clear = (prefetch_en && !pend_any) || state_q == ST_OSTWAIT
                     || state_q == ST_RESUME || su_run;
  assign wdt_run_in_sleep  = wdctl_q[SOFT_WD_EN_BIT];
  // other resets untouched; they act through nrst
  assign wdt_timeout_reset = wdt_timeout && state_q == ST_AWAKE;
  // reset-class wakes arrive via nrst; others resume above

  assign lf_osc_en    = 1'b1;
  assign sec_osc_en   = 1'b1;
  // converter clock and sensing oscillator stay on
  assign conv_clk_en  = 1'b1;
  assign sense_osc_en = 1'b1;
  assign pin_hold     = (state_q != ST_AWAKE);

  // ----------------------------------------------------------------
  // register readback, one cycle latency
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata_q <= 8'h00;
    else if (reg_read)
    begin
      case (reg_addr)
        OFS_INTCTL:  rdata_q <= intctl_q;
        OFS_PEN1:    rdata_q <= pen1_q;
        OFS_PEN2:    rdata_q <= pen2_q;
        OFS_PRQ1:    rdata_q <= prq1_q;
        OFS_PRQ2:    rdata_q <= prq2_q & PRQ2_MASK;
        OFS_STATUS:  rdata_q <= {3'h0, to_n_q, pd_n_q, 3'h0};
        OFS_WDCTL:   rdata_q <= wdctl_q;
        OFS_SLPSTAT: rdata_q <= {4'h0, wake_wdt_q, state_q};
        default:     rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  assign reg_rdata = rdata_q;

  // status write: ignored, both flags are read only
  logic unused_stat;
  assign unused_stat = wr_stat;

endmodule : sleep_wake_control

/* File: test/core_source_model.sv */
// Purpose: stand-in for the cpu core and the oscillator
// Assumes: the bench asks for sleep with a one-cycle request
// Notes:   oscillator tick every 4 system clocks, free running
`timescale 1ns/10ps
module core_source_model
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // bench request and design feedback
  input  wire logic        do_sleep,
  input  wire logic        cpu_clk_en,
  // towards the controller
  output logic             sleep_exec,
  output logic      [15:0] pc,
  output logic             osc_tick
);
  logic [1:0] tick_q;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      sleep_exec <= 1'b0;
    else
      sleep_exec <= do_sleep && cpu_clk_en && !sleep_exec;
  end

  // next slot after sleep counts as a harmless no-operation here
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      pc <= 16'h0100;
    else if (cpu_clk_en)
      pc <= pc + 16'h0001;
  end

  // divided tick so the start-up count spans several clocks
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      tick_q <= 2'h0;
    else
      tick_q <= tick_q + 2'h1;
  end
  assign osc_tick = (tick_q == 2'h3);
endmodule : core_source_model

/* File: test/sleep_wake_control_asserts.sv */
// Purpose: port-level checks for the sleep and wake controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every instance of the controller
`timescale 1ns/10ps
module sleep_wake_control_asserts
  import sleep_wake_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  // core side
  input wire logic        sleep_exec,
  input wire logic [15:0] pc,
  input wire logic        cpu_clk_en,
  input wire logic        prefetch_en,
  input wire logic [15:0] prefetch_addr,
  input wire logic        resume_pulse,
  input wire logic        isr_call,
  input wire logic [15:0] isr_addr,
  // watchdog, keep-alive and pins
  input wire logic        wdt_timeout,
  input wire logic        wdt_clear,
  input wire logic        wdt_timeout_reset,
  input wire logic        lf_osc_en,
  input wire logic        sec_osc_en,
  input wire logic        conv_clk_en,
  input wire logic        sense_osc_en,
  input wire logic        pin_hold
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  a_prefetch: assert property (prefetch_en |-> sleep_exec && prefetch_addr == pc + 16'h0001)
    else $error("prefetch address is not the next instruction");
  a_hold: assert property (cpu_clk_en != pin_hold)
    else $error("pin hold and cpu clock disagree");
  a_alive: assert property (lf_osc_en && sec_osc_en && conv_clk_en && sense_osc_en)
    else $error("a keep-alive clock was switched off");
  a_prq2_low: assert property ($past(reg_read) && $past(reg_addr) == OFS_PRQ2 |-> reg_rdata[2:0] == 3'h0)
    else $error("unimplemented request bits read nonzero");
  // sleep entry only from a taken sleep, watchdog cleared on the way in
  a_enter: assert property ($fell(cpu_clk_en) |-> $past(sleep_exec) && $past(wdt_clear))
    else $error("cpu clock stopped without a cleared sleep entry");
  a_noop: assert property (sleep_exec && cpu_clk_en && !wdt_clear |=> cpu_clk_en)
    else $error("refused sleep still stopped the clock");
  a_wake_clear: assert property ($rose(cpu_clk_en) |-> $past(wdt_clear))
    else $error("watchdog not held clear up to wake");
  a_isr: assert property (isr_call |-> resume_pulse && isr_addr == ISR_VECTOR)
    else $error("service call without vector or resume");
  a_resume: assert property (resume_pulse |-> cpu_clk_en)
    else $error("resume while cpu clock stopped");
  a_wdt_reset: assert property (wdt_timeout_reset |-> cpu_clk_en && wdt_timeout)
    else $error("watchdog reset raised while asleep");
endmodule : sleep_wake_control_asserts

bind sleep_wake_control sleep_wake_control_asserts sleep_wake_control_asserts_i (
  .clock, .nrst, .reg_addr, .reg_read, .reg_rdata, .sleep_exec, .pc, .cpu_clk_en,
  .prefetch_en, .prefetch_addr, .resume_pulse, .isr_call, .isr_addr, .wdt_timeout,
  .wdt_clear, .wdt_timeout_reset, .lf_osc_en, .sec_osc_en, .conv_clk_en,
  .sense_osc_en, .pin_hold);

/* File: test/sleep_wake_control_tb_top.sv */
// Purpose: directed test of sleep entry, wake and request flags
// Assumes: start-up count shortened to 4 oscillator periods
// Notes:   registers stay reachable while the core sleeps
`timescale 1ns/10ps
module sleep_wake_control_tb_top
  import sleep_wake_pkg::*;
;
  logic        clock, nrst, reg_write, reg_read, do_sleep, wdt_timeout, slow_osc_mode;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, prq2_set;
  logic [15:0] pc, isr_addr;
  logic        sleep_exec, osc_tick, cpu_clk_en, resume_pulse, isr_call;
  logic        wdt_run_in_sleep, wdt_timeout_reset, pin_hold;
  int          fails, compares, n;

  sleep_wake_control #(.STARTUP_COUNT(4)) sleep_wake_control_i (
    .clock, .nrst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .sleep_exec, .pc, .cpu_clk_en, .prefetch_en(), .prefetch_addr(), .resume_pulse,
    .isr_call, .isr_addr, .prq1_set(8'h00), .prq2_set, .core_flag_set(3'h0),
    .wdt_timeout, .osc_tick, .slow_osc_mode, .wdt_clear(), .wdt_run_in_sleep,
    .wdt_timeout_reset, .lf_osc_en(), .sec_osc_en(), .conv_clk_en(),
    .sense_osc_en(), .pin_hold);
  core_source_model core_source_model_i (
    .clock, .nrst, .do_sleep, .cpu_clk_en, .sleep_exec, .pc, .osc_tick);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string what);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    chk(what, {8'h00, e}, {8'h00, reg_rdata});
  endtask : rd

  task automatic slp;
    @(posedge clock);
    do_sleep <= 1'b1;
    @(posedge clock);
    do_sleep <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : slp

  task automatic wait_resume;
    n = 0;
    // sampled mid-cycle so the one-cycle pulse is seen while it stands
    while (resume_pulse !== 1'b1 && n < 300)
    begin
      @(negedge clock);
      n++;
    end
    chk("resume seen", 16'h1, {15'h0, resume_pulse});
  endtask : wait_resume

  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // hang guard, far beyond the hundred-odd cycles of the tests
  initial
  begin
    #100us;
    fails++;
    end_sim;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {reg_addr, reg_wdata, reg_write, reg_read, prq2_set} = '0;
    {do_sleep, wdt_timeout, slow_osc_mode, nrst} = '0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    rd(OFS_STATUS, 8'h18, "status reset");
    rd(OFS_PRQ2, 8'h00, "request two reset");
    rd(OFS_WDCTL, 8'h16, "watchdog control reset");
    rd(4'hF, 8'h00, "unmapped index");
    wr(OFS_PRQ2, 8'hFF);
    rd(OFS_PRQ2, 8'hF8, "request two flags");
    wr(OFS_STATUS, 8'h00);
    rd(OFS_STATUS, 8'h18, "status read only");
    wr(OFS_PRQ2, 8'h00);
    wr(OFS_WDCTL, 8'h17);
    @(negedge clock);
    chk("run in sleep", 16'h1, {15'h0, wdt_run_in_sleep});
    // timeout awake resets, timeout asleep wakes
    @(posedge clock) wdt_timeout <= 1'b1;
    @(negedge clock) chk("awake timeout", 16'h1, {15'h0, wdt_timeout_reset});
    @(posedge clock) wdt_timeout <= 1'b0;
    slp;
    @(negedge clock) chk("clock stopped", 16'h0, {15'h0, cpu_clk_en});
    chk("pins held", 16'h1, {15'h0, pin_hold});
    rd(OFS_STATUS, 8'h10, "status asleep");
    @(posedge clock) wdt_timeout <= 1'b1;
    @(posedge clock) wdt_timeout <= 1'b0;
    wait_resume;
    chk("no service on timeout", 16'h0, {15'h0, isr_call});
    rd(OFS_STATUS, 8'h00, "status timeout wake");
    rd(OFS_SLPSTAT, 8'h08, "sleep status wdt wake");
    // enabled flag already pending: sleep is refused
    wr(OFS_PEN2, 8'h80);
    wr(OFS_INTCTL, 8'h40);
    @(posedge clock) prq2_set <= 8'h80;
    @(posedge clock) prq2_set <= 8'h00;
    slp;
    @(negedge clock) chk("refused sleep", 16'h1, {15'h0, cpu_clk_en});
    rd(OFS_STATUS, 8'h00, "status refused");
    // flag during sleep, global enable off then on, fast then slow mode
    for (int g = 0; g < 2; g++)
    begin
      wr(OFS_PRQ2, 8'h00);
      wr(OFS_INTCTL, g ? 8'hC0 : 8'h40);
      slow_osc_mode <= g[0];
      slp;
      prq2_set <= 8'h80;
      @(posedge clock);
      prq2_set <= 8'h00;
      wait_resume;
      chk("service call", {15'h0, g[0]}, {15'h0, isr_call});
      chk("start-up wait", {15'h0, g[0]}, {15'h0, n >= 12});
      rd(OFS_STATUS, 8'h10, "status irq wake");
    end
    end_sim;
  end
endmodule : sleep_wake_control_tb_top
